// ### hdl/scd_engine.sv
// seven-channel xram to peripheral register transfer engine
`timescale 1ns/1ps
`default_nettype none
module scd_engine (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// register port
	input wire logic [scd_pkg::RADDR_W-1:0] reg_addr_i,
	input wire logic [scd_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [scd_pkg::DATA_W-1:0] reg_rdata_o,
	// peripheral requests
	input wire logic [scd_pkg::NUM_CH-1:0] xfer_req_i,
	// xram port
	output logic [scd_pkg::BASE_W-1:0] xram_addr_o,
	output logic xram_rd_o,
	output logic xram_wr_o,
	output logic [scd_pkg::DATA_W-1:0] xram_wdata_o,
	input wire logic [scd_pkg::DATA_W-1:0] xram_rdata_i,
	// peripheral register port
	output scd_pkg::scd_target_t sfr_target_o,
	output logic [scd_pkg::LANE_W-1:0] sfr_lane_o,
	output logic sfr_rd_o,
	output logic sfr_wr_o,
	output logic [scd_pkg::DATA_W-1:0] sfr_wdata_o,
	input wire logic [scd_pkg::DATA_W-1:0] sfr_rdata_i,
	// cpu and system state
	input wire logic cpu_xram_busy_i,
	input wire logic cpu_sfr_busy_i,
	input wire logic debug_halt_i,
	// status
	output logic flag_event_o,
	output logic sleep_ready_o
);
	import scd_pkg::*;

	scd_regs_t r;
	scd_regs_t next_r;
	logic [NUM_CH-1:0] elig;
	logic grant;
	logic [SEL_W-1:0] grant_idx;

	// direction: true when xram is the source
	function automatic logic fn_to_sfr(input logic [DATA_W-1:0] cfg);
		scd_func_t f;
		f = scd_func_t'(cfg[CFG_FUNC_LSB +: CFG_FUNC_W]);
		return !(f == FN_ENC_TO_XRAM || f == FN_SPI_TO_XRAM || f == FN_OUT_TO_XRAM);
	endfunction : fn_to_sfr

	// peripheral register reached by a function
	function automatic scd_target_t fn_target(input logic [DATA_W-1:0] cfg);
		scd_target_t t;
		case (scd_func_t'(cfg[CFG_FUNC_LSB +: CFG_FUNC_W]))
			FN_XRAM_TO_ENC: t = TGT_ENCODER;
			FN_ENC_TO_XRAM: t = TGT_ENCODER;
			FN_XRAM_TO_CRC: t = TGT_CHECKSUM;
			FN_XRAM_TO_SPI: t = TGT_SERIAL;
			FN_SPI_TO_XRAM: t = TGT_SERIAL;
			FN_XRAM_TO_KEY: t = TGT_KEY;
			FN_XRAM_TO_BLOCK: t = cfg[CFG_ALT_BIT] ? TGT_XOR : TGT_BLOCK;
			FN_OUT_TO_XRAM: t = TGT_CIPHER_OUT;
			default: t = TGT_NONE;
		endcase
		return t;
	endfunction : fn_target

	// bytes in one transaction
	function automatic logic [1:0] fn_bytes(input logic [DATA_W-1:0] cfg);
		scd_target_t t;
		t = fn_target(cfg);
		return (t == TGT_ENCODER) ? ENC_TXN_BYTES : ONE_TXN_BYTE;
	endfunction : fn_bytes

	// offset at which the mid-point flag rises
	function automatic logic [OFF_W-1:0] fn_mid(input logic [OFF_W-1:0] sz);
		logic [OFF_W-1:0] half;
		half = sz >> 1;
		return sz[0] ? OFF_W'(half + 10'h001) : half;
	endfunction : fn_mid

	// busy view of every channel
	function automatic logic [NUM_CH-1:0] fn_busy(input scd_regs_t s);
		logic [NUM_CH-1:0] b;
		b = s.force_req;
		if (s.fsm == ST_XFER) begin
			b[s.ach] = 1'b1;
		end
		return b;
	endfunction : fn_busy

	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_elig
			assign elig[c] = r.en[c]
				&& !r.cfg[c][CFG_STALL_BIT]
				&& !r.full[c] && !r.mid[c]
				&& (xfer_req_i[c] || r.force_req[c])
				&& (r.size[c] != '0)
				&& (r.wrap[c] || r.off[c] < r.size[c]);
		end
	endgenerate

	scd_prio_arb #(
		.N(NUM_CH),
		.IW(SEL_W)
	) u_arb (
		.req_i(elig),
		.grant_o(grant),
		.idx_o(grant_idx)
	);

	always_comb begin
		logic stall;
		logic sel_ok;
		logic [NUM_CH-1:0] busy;
		logic have_in;
		scd_entry_t in_e;
		logic out_v;
		scd_entry_t out_e;
		logic [OFF_W-1:0] o;
		logic [OFF_W-1:0] sz;
		logic [OFF_W-1:0] last;
		scd_entry_t tag;
		logic [DATA_W-1:0] cf;
		stall = 1'b0;
		sel_ok = 1'b0;
		busy = '0;
		have_in = 1'b0;
		in_e = '0;
		out_v = 1'b0;
		out_e = '0;
		o = '0;
		sz = '0;
		last = '0;
		tag = '0;
		cf = '0;
		next_r = r;
		next_r.xre = 1'b0;
		next_r.xwe = 1'b0;
		next_r.sre = 1'b0;
		next_r.swe = 1'b0;
		next_r.rdata = '0;
		stall = cpu_xram_busy_i || cpu_sfr_busy_i || debug_halt_i;
		sel_ok = (r.sel < SEL_W'(NUM_CH));
		busy = fn_busy(r);

		// register reads, data valid in the following cycle
		if (reg_rd_i) begin
			case (reg_addr_i)
				REG_SELECT: next_r.rdata = DATA_W'(r.sel);
				REG_CONFIG: next_r.rdata = sel_ok ? r.cfg[r.sel] : '0;
				REG_WRAP: next_r.rdata = sel_ok ? DATA_W'(r.wrap[r.sel]) : '0;
				REG_BASE_LO: next_r.rdata = sel_ok ? r.base[r.sel][7:0] : '0;
				REG_BASE_HI: next_r.rdata = sel_ok ? DATA_W'(r.base[r.sel][11:8]) : '0;
				REG_OFF_LO: next_r.rdata = sel_ok ? r.off[r.sel][7:0] : '0;
				REG_OFF_HI: next_r.rdata = sel_ok ? DATA_W'(r.off[r.sel][9:8]) : '0;
				REG_SIZE_LO: next_r.rdata = sel_ok ? r.size[r.sel][7:0] : '0;
				REG_SIZE_HI: next_r.rdata = sel_ok ? DATA_W'(r.size[r.sel][9:8]) : '0;
				REG_ENABLE: next_r.rdata = DATA_W'(r.en);
				REG_BUSY: next_r.rdata = DATA_W'(busy);
				REG_FULL: next_r.rdata = DATA_W'(r.full);
				REG_MID: next_r.rdata = DATA_W'(r.mid);
				default: next_r.rdata = '0;
			endcase
		end

		// register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				REG_SELECT: next_r.sel = reg_wdata_i[SEL_W-1:0];
				REG_CONFIG: begin
					if (sel_ok) begin
						next_r.cfg[r.sel] = reg_wdata_i;
					end
				end
				REG_WRAP: begin
					if (sel_ok) begin
						next_r.wrap[r.sel] = reg_wdata_i[WRAP_BIT];
					end
				end
				REG_BASE_LO: begin
					if (sel_ok && !busy[r.sel]) begin
						next_r.base[r.sel][7:0] = reg_wdata_i;
					end
				end
				REG_BASE_HI: begin
					if (sel_ok && !busy[r.sel]) begin
						next_r.base[r.sel][11:8] = reg_wdata_i[3:0];
					end
				end
				REG_OFF_LO: begin
					if (sel_ok && !busy[r.sel]) begin
						next_r.off[r.sel][7:0] = reg_wdata_i;
					end
				end
				REG_OFF_HI: begin
					if (sel_ok && !busy[r.sel]) begin
						next_r.off[r.sel][9:8] = reg_wdata_i[1:0];
					end
				end
				REG_SIZE_LO: begin
					if (sel_ok && !busy[r.sel]) begin
						next_r.size[r.sel][7:0] = reg_wdata_i;
					end
				end
				REG_SIZE_HI: begin
					if (sel_ok && !busy[r.sel]) begin
						next_r.size[r.sel][9:8] = reg_wdata_i[1:0];
					end
				end
				REG_ENABLE: next_r.en = reg_wdata_i[NUM_CH-1:0];
				REG_BUSY: next_r.force_req = r.force_req | reg_wdata_i[NUM_CH-1:0];
				REG_FULL: next_r.full = r.full & reg_wdata_i[NUM_CH-1:0];
				REG_MID: next_r.mid = r.mid & reg_wdata_i[NUM_CH-1:0];
				default: ;
			endcase
		end

		// data arriving from the source side this cycle
		next_r.rd_wait = r.xre;
		next_r.w_tag = r.x_tag;
		if (r.rd_wait) begin
			have_in = 1'b1;
			in_e = r.w_tag;
			in_e.data = xram_rdata_i;
		end else if (r.sre) begin
			have_in = 1'b1;
			in_e = r.x_tag;
			in_e.data = sfr_rdata_i;
		end

		// destination writes; a cpu access parks data in the hold slots
		if (!stall) begin
			if (r.hcnt != 2'h0) begin
				out_v = 1'b1;
				out_e = r.hold[0];
				next_r.hold[0] = r.hold[1];
				next_r.hcnt = r.hcnt - 2'h1;
				if (have_in) begin
					next_r.hold[next_r.hcnt] = in_e;
					next_r.hcnt = next_r.hcnt + 2'h1;
				end
			end else if (have_in) begin
				out_v = 1'b1;
				out_e = in_e;
			end
		end else if (have_in) begin
			next_r.hold[r.hcnt[0]] = in_e;
			next_r.hcnt = r.hcnt + 2'h1;
		end
		if (out_v) begin
			if (out_e.to_sfr) begin
				next_r.swe = 1'b1;
				next_r.stgt = out_e.tgt;
				next_r.slane = out_e.lane;
				next_r.swdata = out_e.data;
			end else begin
				next_r.xwe = 1'b1;
				next_r.xaddr = out_e.addr;
				next_r.xwdata = out_e.data;
			end
		end

		// channel sequencing
		case (r.fsm)
			ST_IDLE: begin
				if (grant && !stall && !r.xre && !r.rd_wait && !r.sre && r.hcnt == 2'h0) begin
					next_r.fsm = ST_XFER;
					next_r.ach = grant_idx;
					next_r.nbytes = fn_bytes(r.cfg[grant_idx]);
					next_r.left = fn_bytes(r.cfg[grant_idx]);
					next_r.idx = 2'h0;
					next_r.force_req[grant_idx] = reg_wr_i && reg_addr_i == REG_BUSY
						&& reg_wdata_i[grant_idx];
				end
			end
			ST_XFER: begin
				if (!stall && r.hcnt == 2'h0) begin
					cf = r.cfg[r.ach];
					o = r.off[r.ach];
					sz = r.size[r.ach];
					last = OFF_W'(sz - 10'h001);
					tag.to_sfr = fn_to_sfr(cf);
					tag.tgt = fn_target(cf);
					tag.lane = cf[CFG_ENDIAN_BIT] ? LANE_W'(r.nbytes - 2'h1 - r.idx) : r.idx;
					tag.addr = BASE_W'(r.base[r.ach] + BASE_W'(o));
					tag.data = '0;
					next_r.x_tag = tag;
					if (tag.to_sfr) begin
						next_r.xre = 1'b1;
						next_r.xaddr = tag.addr;
					end else begin
						next_r.sre = 1'b1;
						next_r.stgt = tag.tgt;
						next_r.slane = tag.lane;
					end
					if (o == fn_mid(sz)) begin
						next_r.mid[r.ach] = 1'b1;
					end
					if (o == last) begin
						next_r.full[r.ach] = 1'b1;
					end
					if (o == last && r.wrap[r.ach]) begin
						next_r.off[r.ach] = '0;
					end else begin
						next_r.off[r.ach] = OFF_W'(o + 10'h001);
					end
					next_r.left = r.left - 2'h1;
					next_r.idx = r.idx + 2'h1;
					if (r.left == 2'h1 || o == last) begin
						next_r.fsm = ST_IDLE;
					end
				end
			end
			default: next_r.fsm = ST_IDLE;
		endcase

		// status outputs
		next_r.irq = 1'b0;
		for (int c = 0; c < NUM_CH; c++) begin
			if ((r.full[c] && r.cfg[c][CFG_FULL_IE_BIT]) || (r.mid[c] && r.cfg[c][CFG_MID_IE_BIT])) begin
				next_r.irq = 1'b1;
			end
		end
		next_r.sleep_ok = (r.fsm == ST_IDLE) && (elig == '0) && !r.xre && !r.rd_wait
			&& !r.sre && (r.hcnt == 2'h0);
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= SCD_RESET;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from the state register
	assign reg_rdata_o = r.rdata;
	assign xram_addr_o = r.xaddr;
	assign xram_rd_o = r.xre;
	assign xram_wr_o = r.xwe;
	assign xram_wdata_o = r.xwdata;
	assign sfr_target_o = r.stgt;
	assign sfr_lane_o = r.slane;
	assign sfr_rd_o = r.sre;
	assign sfr_wr_o = r.swe;
	assign sfr_wdata_o = r.swdata;
	assign flag_event_o = r.irq;
	assign sleep_ready_o = r.sleep_ok;
endmodule : scd_engine
`default_nettype wire

// ### hdl/scd_prio_arb.sv
// fixed-priority arbiter, lowest index wins
`timescale 1ns/1ps
`default_nettype none
module scd_prio_arb #(
	parameter int N = 7,
	parameter int IW = 3
) (
	// requests
	input wire logic [N-1:0] req_i,
	// grant
	output logic grant_o,
	output logic [IW-1:0] idx_o
);
	if (N < 1 || (1 << IW) < N) begin : g_bad
		$error("scd_prio_arb: index too narrow for request count");
	end

	always_comb begin
		grant_o = 1'b0;
		idx_o = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req_i[i]) begin
				grant_o = 1'b1;
				idx_o = IW'(i);
			end
		end
	end
endmodule : scd_prio_arb
`default_nettype wire

// ### include/scd_pkg.sv
// constants, types and register map of the seven-channel transfer engine
// Overview of operation
// - seven channels, eight selectable transfer functions
// - channel_select picks channel for per-channel registers
// - config bits 2:0 hold transfer_function_field
// - config holds endian, stall, interrupt enables
// - stall finishes current transfer, blocks new ones
// - address is 12-bit base plus 10-bit offset
// - offset increments after every byte moved
// - offset at size minus one sets full flag
// - mid flag at half size, odd adds one
// - set flags block channel until software clears
// - xram to register two cycles, reverse one
// - only enabled channels transfer
// - busy shown; base, offset, size writes ignored
// - writing busy bit forces a transfer
// - wrap returns offset to zero, continues once software clears full
// - cpu access wins, engine waits
// - fixed priority, channel 0 first, at boundaries
// - stalls in debug halt, reports sleep readiness
// - config bit 7 enables full-length interrupt
package scd_pkg;
	localparam int NUM_CH = 7;
	localparam int SEL_W = 3;
	localparam int BASE_W = 12;
	localparam int OFF_W = 10;
	localparam int DATA_W = 8;
	localparam int RADDR_W = 4;
	localparam int LANE_W = 2;

	// register offsets
	localparam logic [3:0] REG_SELECT = 4'h0;
	localparam logic [3:0] REG_CONFIG = 4'h1;
	localparam logic [3:0] REG_WRAP = 4'h2;
	localparam logic [3:0] REG_BASE_LO = 4'h3;
	localparam logic [3:0] REG_BASE_HI = 4'h4;
	localparam logic [3:0] REG_OFF_LO = 4'h5;
	localparam logic [3:0] REG_OFF_HI = 4'h6;
	localparam logic [3:0] REG_SIZE_LO = 4'h7;
	localparam logic [3:0] REG_SIZE_HI = 4'h8;
	localparam logic [3:0] REG_ENABLE = 4'h9;
	localparam logic [3:0] REG_BUSY = 4'hA;
	localparam logic [3:0] REG_FULL = 4'hB;
	localparam logic [3:0] REG_MID = 4'hC;

	// channel_config fields
	localparam int CFG_FUNC_LSB = 0;
	localparam int CFG_FUNC_W = 3;
	localparam int CFG_ALT_BIT = 3;
	localparam int CFG_ENDIAN_BIT = 4;
	localparam int CFG_STALL_BIT = 5;
	localparam int CFG_MID_IE_BIT = 6;
	localparam int CFG_FULL_IE_BIT = 7;
	localparam int WRAP_BIT = 0;

	// bytes per transaction
	localparam logic [1:0] ENC_TXN_BYTES = 2'h3;
	localparam logic [1:0] ONE_TXN_BYTE = 2'h1;

	typedef enum logic [2:0] {
		FN_XRAM_TO_ENC,
		FN_ENC_TO_XRAM,
		FN_XRAM_TO_CRC,
		FN_XRAM_TO_SPI,
		FN_SPI_TO_XRAM,
		FN_XRAM_TO_KEY,
		FN_XRAM_TO_BLOCK,
		FN_OUT_TO_XRAM
	} scd_func_t;

	typedef enum logic [2:0] {
		TGT_ENCODER,
		TGT_CHECKSUM,
		TGT_SERIAL,
		TGT_KEY,
		TGT_BLOCK,
		TGT_XOR,
		TGT_CIPHER_OUT,
		TGT_NONE
	} scd_target_t;

	typedef enum logic {
		ST_IDLE,
		ST_XFER
	} scd_fsm_t;

	typedef struct packed {
		logic to_sfr;
		scd_target_t tgt;
		logic [LANE_W-1:0] lane;
		logic [BASE_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} scd_entry_t;

	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic [NUM_CH-1:0][DATA_W-1:0] cfg;
		logic [NUM_CH-1:0] wrap;
		logic [NUM_CH-1:0] en;
		logic [NUM_CH-1:0] force_req;
		logic [NUM_CH-1:0] full;
		logic [NUM_CH-1:0] mid;
		logic [NUM_CH-1:0][BASE_W-1:0] base;
		logic [NUM_CH-1:0][OFF_W-1:0] off;
		logic [NUM_CH-1:0][OFF_W-1:0] size;
		scd_fsm_t fsm;
		logic [SEL_W-1:0] ach;
		logic [1:0] left;
		logic [1:0] idx;
		logic [1:0] nbytes;
		scd_entry_t x_tag;
		logic rd_wait;
		scd_entry_t w_tag;
		logic [1:0] hcnt;
		scd_entry_t [1:0] hold;
		logic [DATA_W-1:0] rdata;
		logic [BASE_W-1:0] xaddr;
		logic xre;
		logic xwe;
		logic [DATA_W-1:0] xwdata;
		logic sre;
		logic swe;
		scd_target_t stgt;
		logic [LANE_W-1:0] slane;
		logic [DATA_W-1:0] swdata;
		logic sleep_ok;
		logic irq;
	} scd_regs_t;

	localparam scd_regs_t SCD_RESET = '0;
endpackage : scd_pkg

// ### verification/scd_engine_props.sv
// port assertions of the transfer engine
`timescale 1ns/1ps
`default_nettype none
module scd_engine_props (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// inputs seen
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire logic cpu_xram_busy_i,
	input wire logic cpu_sfr_busy_i,
	input wire logic debug_halt_i,
	// outputs watched
	input wire logic [scd_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic xram_rd_o,
	input wire logic xram_wr_o,
	input wire scd_pkg::scd_target_t sfr_target_o,
	input wire logic sfr_rd_o,
	input wire logic sfr_wr_o,
	input wire logic flag_event_o,
	input wire logic sleep_ready_o
);
	import scd_pkg::*;
	logic stall;
	logic [3:0] pend;
	assign stall = cpu_xram_busy_i | cpu_sfr_busy_i | debug_halt_i;
	// xram reads not yet written to the register side
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pend <= 4'h0;
		end else begin
			pend <= pend + 4'(xram_rd_o) - 4'(sfr_wr_o);
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	property p_rdata_rest;
		!$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
	endproperty
	a_rdata_rest: assert property (p_rdata_rest) else $error("read data off cycle");
	property p_cpu_wins;
		(cpu_xram_busy_i || cpu_sfr_busy_i) |=> !(xram_rd_o || xram_wr_o || sfr_rd_o || sfr_wr_o);
	endproperty
	a_cpu_wins: assert property (p_cpu_wins) else $error("engine moved under cpu");
	property p_halt;
		debug_halt_i |=> !xram_rd_o && !xram_wr_o && !sfr_rd_o && !sfr_wr_o;
	endproperty
	a_halt: assert property (p_halt) else $error("engine moved in halt");
	property p_x2s;
		(xram_rd_o && pend == 4'h0) ##1 !stall |=> sfr_wr_o;
	endproperty
	a_x2s: assert property (p_x2s) else $error("register write late");
	property p_s2x;
		sfr_rd_o && sfr_target_o != TGT_ENCODER && !stall |=> xram_wr_o;
	endproperty
	a_s2x: assert property (p_s2x) else $error("xram write late");
	property p_excl;
		!(xram_rd_o && xram_wr_o) && !(sfr_rd_o && sfr_wr_o);
	endproperty
	a_excl: assert property (p_excl) else $error("two directions at once");
	property p_sleep;
		(xram_rd_o || sfr_rd_o) |=> !sleep_ready_o;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep ready while moving");
	property p_flag;
		$rose(flag_event_o) |-> $past(xram_rd_o || sfr_rd_o) || $past(reg_wr_i)
			|| $past(reg_wr_i, 2);
	endproperty
	a_flag: assert property (p_flag) else $error("event without cause");
	c_x2s: cover property ((xram_rd_o && pend == 4'h0) ##1 !stall);
	c_s2x: cover property (sfr_rd_o && !stall);
	c_flag: cover property ($rose(flag_event_o));
endmodule : scd_engine_props
`default_nettype wire

// ### verification/scd_periph_model.sv
// xram and peripheral register model beside the transfer engine
`timescale 1ns/1ps
`default_nettype none
module scd_periph_model (
	// clock
	input wire logic ref_clk_i,
	// xram side
	input wire logic [11:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	// register side
	input wire scd_pkg::scd_target_t tgt_i,
	input wire logic [1:0] lane_i,
	input wire logic srd_i,
	output logic [7:0] srdata_o
);
	import scd_pkg::*;
	logic [7:0] mem [4096];
	logic [7:0] junk;
	initial begin
		rdata_o = 8'h00;
		junk = 8'h00;
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'(i) ^ {4'(i >> 8), 4'h5};
		end
	end
	// data one cycle after the strobe, inverted once it is stale
	always @(posedge ref_clk_i) begin
		junk <= junk + 8'h3B;
		if (rd_i) begin
			rdata_o <= mem[addr_i];
		end else begin
			rdata_o <= ~rdata_o;
		end
		if (wr_i) begin
			mem[addr_i] <= wdata_i;
		end
	end
	assign srdata_o = srd_i ? {tgt_i, lane_i, 3'h6} : junk;
endmodule : scd_periph_model
`default_nettype wire

// ### verification/test_scd_engine.sv
// self-checking bench of the transfer engine
`timescale 1ns/1ps
`default_nettype none
module test_scd_engine;
	import scd_pkg::*;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wd = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [6:0] req = 7'h00;
	logic cxb = 1'b0;
	logic csb = 1'b0;
	logic dh = 1'b0;
	logic noise = 1'b0;
	logic [7:0] rdata, xwd, xrdat, swd, srdat, v;
	logic [11:0] xa;
	logic xrd, xwr, srd, swr, fev, slp;
	logic [1:0] lane;
	scd_target_t tgt;
	logic [12:0] sq [$];
	int n_mismatch = 0;
	int n_compared = 0;
	always #2.5 ref_clk_i = ~ref_clk_i;
	scd_engine DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .xfer_req_i(req), .xram_addr_o(xa),
		.xram_rd_o(xrd), .xram_wr_o(xwr), .xram_wdata_o(xwd), .xram_rdata_i(xrdat),
		.sfr_target_o(tgt), .sfr_lane_o(lane), .sfr_rd_o(srd), .sfr_wr_o(swr),
		.sfr_wdata_o(swd), .sfr_rdata_i(srdat), .cpu_xram_busy_i(cxb), .cpu_sfr_busy_i(csb),
		.debug_halt_i(dh), .flag_event_o(fev), .sleep_ready_o(slp));
	scd_periph_model u_model (.ref_clk_i(ref_clk_i), .addr_i(xa), .rd_i(xrd), .wr_i(xwr),
		.wdata_i(xwd), .rdata_o(xrdat), .tgt_i(tgt), .lane_i(lane), .srd_i(srd),
		.srdata_o(srdat));
	always @(posedge ref_clk_i) begin
		cxb <= noise && ($urandom % 5 == 0);
		csb <= noise && ($urandom % 7 == 0);
		if (swr === 1'b1) begin
			sq.push_back({tgt, lane, swd});
		end
	end
	function automatic logic [7:0] exp_x(input logic [11:0] a);
		exp_x = a[7:0] ^ {a[11:8], 4'h5};
	endfunction : exp_x
	function automatic scd_target_t tgt_of(input logic [2:0] fn, input logic alt);
		case (fn)
			3'h0, 3'h1: tgt_of = TGT_ENCODER;
			3'h2: tgt_of = TGT_CHECKSUM;
			3'h3, 3'h4: tgt_of = TGT_SERIAL;
			3'h5: tgt_of = TGT_KEY;
			3'h6: tgt_of = alt ? TGT_XOR : TGT_BLOCK;
			default: tgt_of = TGT_CIPHER_OUT;
		endcase
	endfunction : tgt_of
	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
		n_compared++;
		if (e !== g) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task automatic quiet();
		int k;
		k = 0;
		for (int i = 0; i < 400 && k < 6; i++) begin
			@(posedge ref_clk_i);
			k = (slp === 1'b1) ? k + 1 : 0;
		end
		if (k < 6) begin
			n_mismatch++;
			complete_run();
		end
	endtask : quiet
	task automatic setup(input int ch, input logic [7:0] cfg, input logic w,
		input logic [11:0] base, input logic [9:0] size);
		wr_reg(REG_SELECT, 8'(ch));
		wr_reg(REG_CONFIG, cfg);
		wr_reg(REG_WRAP, {7'h00, w});
		wr_reg(REG_BASE_LO, base[7:0]);
		wr_reg(REG_BASE_HI, {4'h0, base[11:8]});
		wr_reg(REG_SIZE_LO, size[7:0]);
		wr_reg(REG_SIZE_HI, {6'h00, size[9:8]});
		wr_reg(REG_OFF_LO, 8'h00);
		wr_reg(REG_OFF_HI, 8'h00);
	endtask : setup
	task automatic run(input int ch, input logic [2:0] fn, input logic alt, input logic big,
		input logic w);
		logic [11:0] base;
		logic [9:0] size, m;
		logic [7:0] cfg;
		logic enc, tox;
		logic [1:0] ln;
		base = 12'($urandom % 3840);
		enc = (fn <= 3'h1);
		tox = (fn == 3'h1 || fn == 3'h4 || fn == 3'h7);
		size = enc ? 10'h006 : 10'(4 + $urandom % 6);
		m = size[0] ? size / 2 + 1 : size / 2;
		cfg = {2'($urandom), 1'b0, big, alt, fn};
		setup(ch, cfg, w, base, size);
		rd_reg(REG_CONFIG);
		chk("config", 13'(cfg), 13'(v));
		sq.delete();
		req[ch] <= 1'b1;
		wr_reg(REG_ENABLE, 8'(1 << ch));
		quiet();
		rd_reg(REG_OFF_LO);
		chk("offset at stop", 13'(enc ? size : m + 1), 13'(v));
		chk("event at stop", 13'(cfg[6] | (enc & cfg[7])), 13'(fev));
		wr_reg(REG_MID, 8'h00);
		quiet();
		rd_reg(REG_OFF_LO);
		chk("offset at end", 13'(w ? 10'h000 : size), 13'(v));
		rd_reg(REG_FULL);
		chk("full flag", 13'(1 << ch), 13'(v));
		chk("event at end", 13'(cfg[7]), 13'(fev));
		for (int k = 0; k < size; k++) begin
			ln = enc ? 2'(big ? 2 - k % 3 : k % 3) : 2'h0;
			if (tox) begin
				chk("xram byte", 13'({tgt_of(fn, alt), ln, 3'h6}),
					13'(u_model.mem[base + 12'(k)]));
				// put the pattern back so later reads of this area still match
				u_model.mem[base + 12'(k)] = exp_x(base + 12'(k));
			end else begin
				chk("reg write", {tgt_of(fn, alt), ln, exp_x(base + 12'(k))},
					sq.pop_front());
			end
		end
		chk("stray writes", 13'h0, 13'(sq.size()));
		req[ch] <= 1'b0;
		wr_reg(REG_ENABLE, 8'h00);
		wr_reg(REG_FULL, 8'h00);
	endtask : run
	initial begin
		void'($urandom(76775));
		repeat (10) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		for (int a = 0; a < 14; a++) begin
			rd_reg(4'(a));
			chk("reset value", 13'h0, 13'(v));
		end
		chk("sleep ready", 13'h1, 13'(slp));
		wr_reg(REG_SELECT, 8'h07);
		wr_reg(REG_CONFIG, 8'hFF);
		rd_reg(REG_CONFIG);
		chk("no channel 7", 13'h0, 13'(v));
		$display("test reset done");
		noise <= 1'b1;
		for (int i = 0; i < 18; i++) begin
			run(i % 7, 3'(i % 8), i == 14, i == 8 || i == 9, i % 8 == 5);
		end
		$display("test functions done");
		setup(4, 8'h03, 1'b0, 12'h800, 10'h004);
		setup(1, 8'h03, 1'b0, 12'h100, 10'h004);
		wr_reg(REG_ENABLE, 8'h12);
		sq.delete();
		req <= 7'h12;
		quiet();
		chk("first grant", {TGT_SERIAL, 2'h0, exp_x(12'h100)}, sq[0]);
		chk("later grant", {TGT_SERIAL, 2'h0, exp_x(12'h800)}, sq[3]);
		req <= 7'h00;
		wr_reg(REG_ENABLE, 8'h00);
		wr_reg(REG_MID, 8'h00);
		$display("test priority done");
		noise <= 1'b0;
		setup(2, 8'h20, 1'b0, 12'h3C0, 10'h009);
		sq.delete();
		req <= 7'h04;
		quiet();
		chk("disabled", 13'h0, 13'(sq.size()));
		wr_reg(REG_ENABLE, 8'h04);
		quiet();
		chk("stalled", 13'h0, 13'(sq.size()));
		rd_reg(REG_BUSY);
		chk("stalled busy", 13'h0, 13'(v));
		req <= 7'h00;
		wr_reg(REG_CONFIG, 8'h00);
		wr_reg(REG_BUSY, 8'h04);
		quiet();
		rd_reg(REG_OFF_LO);
		chk("forced", 13'h3, 13'(v));
		req <= 7'h04;
		for (int i = 0; i < 60 && xrd !== 1'b1; i++) begin
			@(posedge ref_clk_i);
			#1;
		end
		if (xrd !== 1'b1) begin
			n_mismatch++;
			complete_run();
		end
		dh <= 1'b1;
		rd_reg(REG_BUSY);
		chk("busy in halt", 13'h4, 13'(v));
		wr_reg(REG_BASE_LO, 8'h55);
		dh <= 1'b0;
		quiet();
		rd_reg(REG_BASE_LO);
		chk("base kept", 13'hC0, 13'(v));
		rd_reg(REG_OFF_LO);
		chk("after halt", 13'h6, 13'(v));
		chk("bytes moved", 13'h6, 13'(sq.size()));
		req <= 7'h00;
		$display("test control done");
		complete_run();
	end
endmodule : test_scd_engine
bind scd_engine scd_engine_props u_props (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
	.reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .cpu_xram_busy_i(cpu_xram_busy_i),
	.cpu_sfr_busy_i(cpu_sfr_busy_i), .debug_halt_i(debug_halt_i), .reg_rdata_o(reg_rdata_o),
	.xram_rd_o(xram_rd_o), .xram_wr_o(xram_wr_o), .sfr_target_o(sfr_target_o),
	.sfr_rd_o(sfr_rd_o), .sfr_wr_o(sfr_wr_o), .flag_event_o(flag_event_o),
	.sleep_ready_o(sleep_ready_o));
`default_nettype wire
